// ===== hdl/sdlb_log_button_control.sv
// logging button classifier, mount control and card link top
`include "sdlb_cfg.svh"

// Functional notes
// - a press held 100 ms to 5 s, then released, flips logging.
// - a press over 5 s acts on release, flipping the card mount.
// - the logging indicator shows whether the card is mounted.
// - the button is debounced inside, no outside filter needed.
// - the card runs one data line, with clock and command driven.
// - the card clock never runs above 33 MHz.
// - the button is active low, pulled up, pulled low to request.
module sdlb_log_button_control #(
  parameter int unsigned DEBOUNCE_CYC = `SDLB_DEBOUNCE_CYC,
  parameter int unsigned SHORT_CYC = `SDLB_SHORT_CYC,
  parameter int unsigned LONG_CYC = `SDLB_LONG_CYC
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic log_button_n_i,
  input wire logic card_link_clk_i,
  input wire logic card_data_line0_i,
  output logic card_clock_out_o,
  output logic card_command_line_o,
  output logic card_data_line0_o,
  output logic card_data_line0_oe_n_o,
  output logic log_status_indicator_o,
  output logic log_enable_o
);

  localparam int unsigned CW = 32;

  // the card clock is the link clock halved; the link must stay legal
  localparam int unsigned CARD_KHZ = `SDLB_LINK_CLK_KHZ / `SDLB_CARD_DIV;
  localparam bit CARD_CLK_OK = CARD_KHZ <= `SDLB_CARD_CLK_MAX_KHZ;

  // button synchroniser
  logic btn_s1_q;
  logic btn_s2_q;

  // debounce
  logic db_q, db_d;
  logic [CW-1:0] db_cnt_q, db_cnt_d;
  logic db_flip;
  logic rel;

  // press length classification
  sdlb_pkg::sdlb_btn_state_type bst_q, bst_d;
  logic [CW-1:0] hold_cnt_q, hold_cnt_d;
  logic short_ok;
  logic long_ok;
  logic too_short;

  // logging and mount state
  logic log_en_q, log_en_d;
  logic mounted_q, mounted_d;
  logic busy_q, busy_d;
  logic op_mount_q, op_mount_d;
  logic req_tgl_q, req_tgl_d;

  // completion coming back from the link domain
  logic done_tgl;
  logic done_s1_q;
  logic done_s2_q;
  logic done_s3_q;
  logic done_evt;

  // the pin is asynchronous to clk_i: two flops before any use
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      btn_s1_q <= 1'b1;
      btn_s2_q <= 1'b1;
    end else begin
      btn_s1_q <= log_button_n_i;
      btn_s2_q <= btn_s1_q;
    end
  end

  // a level change is accepted only after it stood for the debounce time
  always_comb begin
    db_d = db_q;
    db_cnt_d = '0;
    db_flip = 1'b0;
    if (btn_s2_q != db_q) begin
      if (db_cnt_q == DEBOUNCE_CYC - 1) begin
        db_d = btn_s2_q;
        db_flip = 1'b1;
      end else begin
        db_cnt_d = db_cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      db_q <= 1'b1;
      db_cnt_q <= '0;
    end else begin
      db_q <= db_d;
      db_cnt_q <= db_cnt_d;
    end
  end

  assign rel = db_flip && !db_q;

  // press length, saturating just past the long threshold
  assign too_short = hold_cnt_q < SHORT_CYC;
  assign short_ok = !too_short && hold_cnt_q <= LONG_CYC;
  assign long_ok = hold_cnt_q > LONG_CYC;

  always_comb begin
    bst_d = bst_q;
    hold_cnt_d = hold_cnt_q;
    case (bst_q)
      sdlb_pkg::BTN_IDLE: begin
        hold_cnt_d = '0;
        if (db_flip && db_q) begin
          bst_d = sdlb_pkg::BTN_HELD;
        end
      end
      sdlb_pkg::BTN_HELD: begin
        if (hold_cnt_q <= LONG_CYC) begin
          hold_cnt_d = hold_cnt_q + 1'b1;
        end
        if (rel) begin
          bst_d = sdlb_pkg::BTN_IDLE;
        end
      end
      default: bst_d = sdlb_pkg::BTN_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      bst_q <= sdlb_pkg::BTN_IDLE;
      hold_cnt_q <= '0;
    end else begin
      bst_q <= bst_d;
      hold_cnt_q <= hold_cnt_d;
    end
  end

  // completion toggle from the link crosses through two flops
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      done_s3_q <= 1'b0;
    end else begin
      done_s1_q <= done_tgl;
      done_s2_q <= done_s1_q;
      done_s3_q <= done_s2_q;
    end
  end

  assign done_evt = done_s2_q ^ done_s3_q;

  // a long release while a mount change is in flight is dropped
  always_comb begin
    log_en_d = log_en_q;
    mounted_d = mounted_q;
    busy_d = busy_q;
    op_mount_d = op_mount_q;
    req_tgl_d = req_tgl_q;
    if (rel && short_ok) begin
      log_en_d = ~log_en_q;
    end
    if (rel && long_ok && !busy_q) begin
      busy_d = 1'b1;
      op_mount_d = ~mounted_q;
      req_tgl_d = ~req_tgl_q;
    end
    if (busy_q && done_evt) begin
      busy_d = 1'b0;
      mounted_d = op_mount_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      log_en_q <= 1'b0;
      mounted_q <= 1'b0;
      busy_q <= 1'b0;
      op_mount_q <= 1'b0;
      req_tgl_q <= 1'b0;
    end else begin
      log_en_q <= log_en_d;
      mounted_q <= mounted_d;
      busy_q <= busy_d;
      op_mount_q <= op_mount_d;
      req_tgl_q <= req_tgl_d;
    end
  end

  assign log_enable_o = log_en_q;
  assign log_status_indicator_o = mounted_q;

  sdlb_card_link u_link (
    .link_clk_i(card_link_clk_i),
    .reset_n_i(reset_n_i),
    .req_tgl_i(req_tgl_q),
    .op_mount_i(op_mount_q),
    .card_data_line0_i(card_data_line0_i),
    .done_tgl_o(done_tgl),
    .card_clock_out_o(card_clock_out_o),
    .card_command_line_o(card_command_line_o),
    .card_data_line0_o(card_data_line0_o),
    .card_data_line0_oe_n_o(card_data_line0_oe_n_o)
  );

  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  chk_card_clk_limit: assert property (
    CARD_CLK_OK)
    else $error("link clock setting puts the card clock above its limit");

  chk_short_toggle: assert property (
    rel && short_ok |=> log_en_q != $past(log_en_q) && $stable(req_tgl_q))
    else $error("mid-length press did not flip logging");

  sequence s_long_release;
    rel && long_ok && !busy_q;
  endsequence

  chk_long_request: assert property (
    s_long_release |=> busy_q && req_tgl_q != $past(req_tgl_q)
      && op_mount_q == !$past(mounted_q) && $stable(log_en_q))
    else $error("long press did not start a mount change");

  chk_held_quiet: assert property (
    !db_q && !rel |=> $stable(log_en_q) && $stable(req_tgl_q))
    else $error("state changed while the button was still held");

  chk_short_ignored: assert property (
    rel && too_short |=> $stable(log_en_q) && $stable(req_tgl_q)
      && $stable(mounted_q))
    else $error("press under the short limit changed state");

  chk_indicator_done: assert property (
    busy_q && done_evt |=> log_status_indicator_o == $past(op_mount_q)
      && !busy_q)
    else $error("indicator did not follow the completed mount change");

  chk_indicator_cause: assert property (
    $changed(log_status_indicator_o) |-> $past(busy_q) && $past(done_evt))
    else $error("indicator moved without a finished mount change");

  chk_debounce_wait: assert property (
    $changed(db_q) |-> $past(btn_s2_q) != $past(db_q)
      && $past(db_cnt_q) == DEBOUNCE_CYC - 1)
    else $error("debounced level moved before the debounce time");

  chk_pullup_idle: assert property (
    btn_s2_q && db_q |=> db_q)
    else $error("released button was taken as pressed");

  chk_press_taken: assert property (
    !btn_s2_q && db_q && db_cnt_q == DEBOUNCE_CYC - 1 |=> !db_q)
    else $error("low button level was not taken as a press");

  chk_release_taken: assert property (
    btn_s2_q && !db_q && db_cnt_q == DEBOUNCE_CYC - 1 |=> db_q)
    else $error("high button level was not taken as a release");

  chk_bounce_reset: assert property (
    btn_s2_q == db_q |=> db_cnt_q == '0)
    else $error("debounce count kept running through a bounce");

  chk_press_start: assert property (
    db_flip && db_q |=> bst_q == sdlb_pkg::BTN_HELD && hold_cnt_q == '0)
    else $error("debounced press did not start the hold count");

  chk_release_ends: assert property (
    rel |=> bst_q == sdlb_pkg::BTN_IDLE ##1 hold_cnt_q == '0)
    else $error("release did not end the hold count");

  chk_hold_saturate: assert property (
    hold_cnt_q <= LONG_CYC + 1)
    else $error("hold count ran past its saturation point");

  chk_log_cause: assert property (
    $changed(log_en_q) |-> $past(rel) && $past(short_ok))
    else $error("logging flipped without a mid-length release");

  chk_req_cause: assert property (
    $changed(req_tgl_q) |-> $past(rel) && $past(long_ok) && !$past(busy_q))
    else $error("mount request raised without a long release");

  chk_busy_hold: assert property (
    busy_q && !done_evt |=> busy_q && $stable(req_tgl_q))
    else $error("second mount request while one is in flight");

  sequence s_link_done;
    busy_q && done_evt;
  endsequence

  chk_done_clears: assert property (
    s_link_done |=> !busy_q && $stable(req_tgl_q))
    else $error("finished mount change left the request busy");

  chk_mount_idle: assert property (
    !busy_q |=> $stable(log_status_indicator_o))
    else $error("indicator moved with no mount change in flight");

endmodule : sdlb_log_button_control

// ===== hdl/sdlb_cfg.svh
// constants for the card logging button control block
`ifndef SDLB_CFG_SVH
`define SDLB_CFG_SVH

`define SDLB_CLK_MHZ 100
`define SDLB_DEBOUNCE_MS 10
`define SDLB_SHORT_MS 100
`define SDLB_LONG_MS 5000
`define SDLB_DEBOUNCE_CYC (`SDLB_DEBOUNCE_MS * 1000 * `SDLB_CLK_MHZ)
`define SDLB_SHORT_CYC (`SDLB_SHORT_MS * 1000 * `SDLB_CLK_MHZ)
`define SDLB_LONG_CYC (`SDLB_LONG_MS * 1000 * `SDLB_CLK_MHZ)

`define SDLB_CARD_CLK_MAX_KHZ 33000
`define SDLB_LINK_CLK_KHZ 8000
`define SDLB_CARD_DIV 2
`define SDLB_FRAME_BITS 11
`define SDLB_BIT_CNT_W 4
`define SDLB_CMD_MOUNT 8'h07
`define SDLB_CMD_UNMOUNT 8'h0f
`define SDLB_ACK_TIMEOUT 8'h40
`define SDLB_TMO_W 8

`endif

// ===== hdl/sdlb_pkg.sv
// types shared by the card logging button control block
package sdlb_pkg;

  typedef enum logic [1:0] {
    BTN_IDLE,
    BTN_HELD
  } sdlb_btn_state_type;

  typedef enum logic [1:0] {
    LNK_IDLE,
    LNK_SEND,
    LNK_WAIT,
    LNK_DONE
  } sdlb_link_state_type;

endpackage : sdlb_pkg

// ===== hdl/sdlb_card_link.sv
// card-side command link, clocked by the link clock
`include "sdlb_cfg.svh"

module sdlb_card_link (
  input wire logic link_clk_i,
  input wire logic reset_n_i,
  input wire logic req_tgl_i,
  input wire logic op_mount_i,
  input wire logic card_data_line0_i,
  output logic done_tgl_o,
  output logic card_clock_out_o,
  output logic card_command_line_o,
  output logic card_data_line0_o,
  output logic card_data_line0_oe_n_o
);

  localparam int unsigned FB = `SDLB_FRAME_BITS;

  logic rst_s1_q, rst_s2_q;
  logic req_s1_q, req_s2_q, req_s3_q;
  logic dat_s1_q, dat_s2_q;
  logic clk_q, clk_d;
  logic cmd_q, cmd_d;
  logic done_q, done_d;
  logic oe_n_q, oe_n_d;
  logic [FB-1:0] sh_q, sh_d;
  logic [`SDLB_BIT_CNT_W-1:0] bit_q, bit_d;
  logic [`SDLB_TMO_W-1:0] tmo_q, tmo_d;
  logic seen_busy_q, seen_busy_d;
  sdlb_pkg::sdlb_link_state_type st_q, st_d;
  logic req_evt;

  // reset, the request toggle and the data line enter the link domain through two flops
  always_ff @(posedge link_clk_i) begin
    rst_s1_q <= reset_n_i;
    rst_s2_q <= rst_s1_q;
    req_s1_q <= req_tgl_i;
    req_s2_q <= req_s1_q;
    req_s3_q <= req_s2_q;
    dat_s1_q <= card_data_line0_i;
    dat_s2_q <= dat_s1_q;
  end

  assign req_evt = req_s2_q ^ req_s3_q;

  always_comb begin
    clk_d = ~clk_q;
    st_d = st_q;
    cmd_d = cmd_q;
    sh_d = sh_q;
    bit_d = bit_q;
    tmo_d = tmo_q;
    done_d = done_q;
    oe_n_d = oe_n_q;
    seen_busy_d = seen_busy_q;
    case (st_q)
      sdlb_pkg::LNK_IDLE: begin
        cmd_d = 1'b1;
        oe_n_d = 1'b0;
        if (req_evt) begin
          sh_d = {2'b01, op_mount_i ? `SDLB_CMD_MOUNT : `SDLB_CMD_UNMOUNT,
                  1'b1};
          bit_d = '0;
          st_d = sdlb_pkg::LNK_SEND;
        end
      end
      sdlb_pkg::LNK_SEND: begin
        // shift while the card clock is high so bits change on its fall
        if (clk_q) begin
          cmd_d = sh_q[FB-1];
          sh_d = {sh_q[FB-2:0], 1'b1};
          bit_d = bit_q + 1'b1;
          if (bit_q == `SDLB_BIT_CNT_W'(FB - 1)) begin
            st_d = sdlb_pkg::LNK_WAIT;
            tmo_d = '0;
            seen_busy_d = 1'b0;
          end
        end
      end
      sdlb_pkg::LNK_WAIT: begin
        cmd_d = 1'b1;
        oe_n_d = 1'b1;
        tmo_d = tmo_q + 1'b1;
        if (!dat_s2_q) begin
          seen_busy_d = 1'b1;
        end
        if ((seen_busy_q && dat_s2_q) || tmo_q == `SDLB_ACK_TIMEOUT) begin
          st_d = sdlb_pkg::LNK_DONE;
        end
      end
      sdlb_pkg::LNK_DONE: begin
        done_d = ~done_q;
        st_d = sdlb_pkg::LNK_IDLE;
      end
      default: st_d = sdlb_pkg::LNK_IDLE;
    endcase
  end

  always_ff @(posedge link_clk_i) begin
    if (!rst_s2_q) begin
      clk_q <= 1'b0;
      st_q <= sdlb_pkg::LNK_IDLE;
      cmd_q <= 1'b1;
      sh_q <= '1;
      bit_q <= '0;
      tmo_q <= '0;
      done_q <= 1'b0;
      oe_n_q <= 1'b0;
      seen_busy_q <= 1'b0;
    end else begin
      clk_q <= clk_d;
      st_q <= st_d;
      cmd_q <= cmd_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      tmo_q <= tmo_d;
      done_q <= done_d;
      oe_n_q <= oe_n_d;
      seen_busy_q <= seen_busy_d;
    end
  end

  assign done_tgl_o = done_q;
  assign card_clock_out_o = clk_q;
  assign card_command_line_o = cmd_q;
  assign card_data_line0_o = 1'b1;
  assign card_data_line0_oe_n_o = oe_n_q;

  default clocking @(posedge link_clk_i); endclocking
  default disable iff (!rst_s2_q);

  chk_card_clk_div: assert property (
    $past(rst_s2_q) |-> clk_q != $past(clk_q))
    else $error("card clock did not toggle at half link rate");

  sequence s_frame_go;
    st_q == sdlb_pkg::LNK_IDLE && req_evt;
  endsequence

  chk_cmd_start_bit: assert property (
    s_frame_go ##1 (st_q == sdlb_pkg::LNK_SEND && clk_q) |=> !cmd_q)
    else $error("command frame did not open with a low start bit");

  chk_data_released: assert property (
    st_q == sdlb_pkg::LNK_WAIT |=> oe_n_q || st_q == sdlb_pkg::LNK_IDLE)
    else $error("data line driven while waiting for the card");

endmodule : sdlb_card_link

// ===== tb/sdlb_card_model.sv
// card partner model: takes command frames and answers busy then ready
module sdlb_card_model (
  input wire logic card_clock_out_i,
  input wire logic card_command_line_i,
  input wire logic card_data_line0_oe_n_i,
  output logic card_busy_n_o,
  output logic [7:0] last_cmd_o,
  output int frames_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [10:0] shift_q;
  int bit_cnt;
  initial begin
    card_busy_n_o = 1'b1;
    last_cmd_o = 8'h00;
    frames_o = 0;
    bit_cnt = 0;
    shift_q = '0;
  end
  // one bit per card clock, taken while the card clock rises
  always @(posedge card_clock_out_i) begin
    if (bit_cnt > 0 || card_command_line_i === 1'b0) begin
      shift_q = {shift_q[9:0], card_command_line_i};
      bit_cnt = bit_cnt + 1;
      if (bit_cnt == 11) begin
        last_cmd_o = shift_q[8:1];
        frames_o = frames_o + 1;
        bit_cnt = 0;
      end
    end
  end
  // busy low on the single data line once the device lets go of it
  always @(posedge card_data_line0_oe_n_i) begin
    card_busy_n_o = 1'b0;
    repeat (6) @(posedge card_clock_out_i);
    card_busy_n_o = 1'b1;
  end
endmodule : sdlb_card_model

// ===== tb/sdlb_log_button_control_test.sv
// testbench for the card logging button control block
`define CHK(a, e, m) begin checked++; if ((a) !== (e)) begin \
  mismatches++; $display("[FAIL] %0t %s", $time, m); end end

module sdlb_log_button_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n_i = 1'b0;
  logic btn_n = 1'b1;
  logic data_wire;
  logic card_clk, cmd_line, data_o, oe_n, indicator, log_en, busy_n;
  logic [7:0] last_cmd;
  int frames;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;

  always #5 clk_i = ~clk_i;
  always #62.5 link_clk = ~link_clk;

  // pulled-up wire: device drives when its enable is low, else the card
  assign data_wire = !oe_n ? data_o : busy_n;

  sdlb_log_button_control #(
    .DEBOUNCE_CYC(8), .SHORT_CYC(100), .LONG_CYC(400)
  ) DUT (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .log_button_n_i(btn_n),
    .card_link_clk_i(link_clk),
    .card_data_line0_i(data_wire),
    .card_clock_out_o(card_clk),
    .card_command_line_o(cmd_line),
    .card_data_line0_o(data_o),
    .card_data_line0_oe_n_o(oe_n),
    .log_status_indicator_o(indicator),
    .log_enable_o(log_en)
  );

  sdlb_card_model card (
    .card_clock_out_i(card_clk),
    .card_command_line_i(cmd_line),
    .card_data_line0_oe_n_i(oe_n),
    .card_busy_n_o(busy_n),
    .last_cmd_o(last_cmd),
    .frames_o(frames)
  );

  task automatic conclude;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      $display("[FAIL] %0t timeout", $time);
      conclude();
    end
  end

  // pull the button low for n cycles, release, let the filter settle
  task automatic hold_button(input int n);
    @(posedge clk_i) #1 btn_n = 1'b0;
    repeat (n) @(posedge clk_i);
    #1 btn_n = 1'b1;
    repeat (30) @(posedge clk_i);
  endtask : hold_button

  task automatic test_reset_idle;
    `CHK(indicator, 1'b0, "indicator after reset")
    `CHK(log_en, 1'b0, "logging after reset")
    `CHK(cmd_line, 1'b1, "command line idle")
    `CHK(data_o, 1'b1, "data line held high")
    `CHK(oe_n, 1'b0, "data line driven at idle")
    $display("test reset_idle done");
  endtask : test_reset_idle

  task automatic test_short_press;
    // bounces shorter than the filter ahead of a real press
    repeat (3) begin
      @(posedge clk_i) #1 btn_n = 1'b0;
      repeat (3) @(posedge clk_i);
      #1 btn_n = 1'b1;
    end
    hold_button(120);
    `CHK(log_en, 1'b1, "short press sets logging")
    `CHK(indicator, 1'b0, "short press keeps mount")
    hold_button(380);
    `CHK(log_en, 1'b0, "short press clears logging")
    `CHK(frames, 0, "no frame for short press")
    $display("test short_press done");
  endtask : test_short_press

  task automatic test_glitch;
    hold_button(4);
    `CHK(log_en, 1'b0, "bounce ignored")
    hold_button(50);
    `CHK(log_en, 1'b0, "brief press ignored")
    `CHK(indicator, 1'b0, "brief press keeps mount")
    $display("test glitch done");
  endtask : test_glitch

  task automatic test_long_press(input logic exp_ind, input logic [7:0] cmd);
    int n;
    logic log_before;
    log_before = log_en;
    n = frames;
    @(posedge clk_i) #1 btn_n = 1'b0;
    repeat (600) @(posedge clk_i);
    `CHK(indicator, !exp_ind, "no change while held")
    #1 btn_n = 1'b1;
    for (int i = 0; i < 3000 && indicator !== exp_ind; i++) begin
      @(posedge clk_i);
    end
    #1;
    `CHK(indicator, exp_ind, "mount flipped on release")
    `CHK(last_cmd, cmd, "mount command code")
    `CHK(frames, n + 1, "one frame per change")
    `CHK(log_en, log_before, "logging untouched")
    repeat (30) @(posedge clk_i);
    `CHK(oe_n, 1'b0, "data line driven again")
    $display("test long_press done");
  endtask : test_long_press

  task automatic test_card_clock;
    realtime t0;
    realtime t1;
    @(posedge card_clk) t0 = $realtime;
    @(posedge card_clk) t1 = $realtime;
    `CHK((t1 - t0) >= 30.3, 1'b1, "card clock too fast")
    $display("test card_clock done");
  endtask : test_card_clock

  task automatic test_log_mounted;
    hold_button(150);
    `CHK(log_en, 1'b1, "logging while mounted")
    `CHK(indicator, 1'b1, "short press keeps mount")
    $display("test log_mounted done");
  endtask : test_log_mounted

  initial begin
    repeat (12) @(posedge link_clk);
    @(posedge clk_i) #1 reset_n_i = 1'b1;
    repeat (20) @(posedge clk_i);
    test_reset_idle();
    test_card_clock();
    test_short_press();
    test_glitch();
    test_long_press(1'b1, 8'h07);
    test_log_mounted();
    test_long_press(1'b0, 8'h0f);
    conclude();
  end
endmodule : sdlb_log_button_control_test
